// ---- design/asd_decoder.sv ----
module asd_decoder
    import asd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // serial link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    // conversion interface
    input wire logic result_ready_n,
    input wire logic conv_done,
    input wire logic [7:0] rd_data,
    // register access
    output logic [4:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    // control outputs
    output logic standby,
    output logic converting,
    output logic cont_mode,
    output logic filter_restart,
    output logic regs_default,
    output logic offset_cal,
    output logic result_load,
    output logic resetting
);
    import asd_pkg::*;

    // ------------------------------------------------------------
    // link synchronisers and byte shifter
    // ------------------------------------------------------------
    logic cs_n_s;
    logic sclk_s;
    logic din_s;
    logic rise;
    logic fall;
    logic [7:0] shreg;
    logic [4:0] bit_cnt;
    logic ready_s;

    asd_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (.sys_clk(sys_clk),
        .rst_n(rst_n), .din(cs_n), .dout(cs_n_s));
    asd_sync u_sync_sclk (.sys_clk(sys_clk), .rst_n(rst_n), .din(sclk),
        .dout(sclk_s));
    asd_sync u_sync_din (.sys_clk(sys_clk), .rst_n(rst_n), .din(din),
        .dout(din_s));
    asd_sync #(.RESET_LEVEL(1'b1)) u_sync_rdy (.sys_clk(sys_clk),
        .rst_n(rst_n), .din(result_ready_n), .dout(ready_s));

    asd_shift u_shift (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cs_n_s(cs_n_s),
        .sclk_s(sclk_s),
        .din_s(din_s),
        .rise(rise),
        .fall(fall),
        .shreg(shreg),
        .bit_cnt(bit_cnt)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // position of current bit within its byte, 1..7 after the fall, 0 for the eighth
    function automatic logic [2:0] bit_in_byte(input logic [4:0] cnt);
        bit_in_byte = cnt[2:0];
    endfunction

    function automatic logic is_sys_op(input logic [6:0] top7);
        logic [7:0] b;
        b = {top7, 1'b0};
        is_sys_op = (b == WAKE_OP) || (b == STANDBY_OP) ||
            (b == RESET_OP) || (b == START_OP) ||
            (b == STOP_OP) || (b == OFFSET_CALIBRATE_CMD) ||
            (b == READ_ONCE_OP);
    endfunction

    // seventh fall: six bits held plus the one arriving; bit 0 unknown,
    // so continuous on/off (10h/11h) wait for the eighth fall
    logic [6:0] top7;
    logic at7;
    logic at8;
    logic [7:0] byte_now;
    assign top7 = {shreg[5:0], din_s};
    assign at7 = fall && bit_in_byte(bit_cnt + 5'h01) == 3'(SYS_DECODE_EDGE);
    assign at8 = fall && bit_in_byte(bit_cnt + 5'h01) == 3'h0;
    assign byte_now = {shreg[6:0], din_s};

    // ------------------------------------------------------------
    // command state machine
    // ------------------------------------------------------------
    asd_state_t state;
    asd_state_t next_state;
    logic [4:0] count;
    logic [4:0] addr;
    logic is_read;
    logic [2:0] rbit;
    logic [7:0] tx;
    logic [5:0] rst_cnt;
    logic sys_hit;
    logic pending_stop;

    assign sys_hit = state == ASD_IDLE && at7 && is_sys_op(top7);

    always_comb begin
        next_state = state;
        case (state)
            ASD_IDLE: begin
                if (at8 && byte_now[7:5] == REGISTER_READ_CMD) begin
                    next_state = cont_mode ? ASD_SKIP : ASD_ARG;
                end else if (at8 && byte_now[7:5] == REGISTER_WRITE_CMD) begin
                    next_state = ASD_ARG;
                end
            end
            ASD_ARG: begin
                if (at8) begin
                    if (byte_now[7:5] != SECOND_BYTE_TOP) begin
                        next_state = ASD_SKIP;
                    end else begin
                        next_state = is_read ? ASD_RDATA : ASD_WDATA;
                    end
                end
            end
            ASD_RDATA, ASD_WDATA: begin
                if (at8 && count == 5'h00) begin
                    next_state = ASD_SKIP;
                end
            end
            ASD_SKIP: next_state = ASD_SKIP;
            default: next_state = ASD_IDLE;
        endcase
        if (cs_n_s) begin
            next_state = ASD_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ASD_IDLE;
        end else if (resetting) begin
            state <= ASD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // address and count tracking
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr <= 5'h00;
            count <= 5'h00;
            is_read <= 1'b0;
        end else if (at8) begin
            if (state == ASD_IDLE) begin
                addr <= byte_now[4:0];
                is_read <= byte_now[7:5] == REGISTER_READ_CMD;
            end else if (state == ASD_ARG) begin
                count <= byte_now[4:0];
            end else if (state == ASD_RDATA || state == ASD_WDATA) begin
                addr <= addr + 5'h01;
                count <= count - 5'h01;
            end
        end
    end

    // register strobes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_addr <= 5'h00;
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            reg_wdata <= 8'h00;
        end else begin
            reg_rd <= 1'b0;
            reg_wr <= 1'b0;
            if (at8 && state == ASD_ARG && is_read &&
                byte_now[7:5] == SECOND_BYTE_TOP) begin
                reg_addr <= addr;
                reg_rd <= 1'b1;
            end else if (at8 && state == ASD_RDATA && count != 5'h00) begin
                reg_addr <= addr + 5'h01;
                reg_rd <= 1'b1;
            end else if (at8 && state == ASD_WDATA) begin
                reg_addr <= addr;
                reg_wdata <= byte_now;
                reg_wr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // output shifter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx <= 8'h00;
            rbit <= 3'h0;
            dout <= 1'b0;
        end else if (cs_n_s) begin
            rbit <= 3'h0;
            dout <= 1'b0;
        end else if (rise && (state == ASD_RDATA ||
            (cont_mode && state == ASD_IDLE))) begin
            // first rise after sixteen bits, or the first rise of a frame in continuous mode, carries the msb
            dout <= (rbit == 3'h0) ? rd_data[7] : tx[7];
            tx <= (rbit == 3'h0) ? {rd_data[6:0], 1'b0} : {tx[6:0], 1'b0};
            rbit <= rbit + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // system command effects
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby <= STANDBY_RESET;
            cont_mode <= CONT_MODE_RESET;
            offset_cal <= 1'b0;
            filter_restart <= 1'b0;
            regs_default <= 1'b0;
            rst_cnt <= 6'h00;
            resetting <= 1'b0;
        end else begin
            offset_cal <= 1'b0;
            filter_restart <= 1'b0;
            regs_default <= 1'b0;
            if (resetting) begin
                rst_cnt <= rst_cnt - 6'h01;
                if (rst_cnt == 6'h01) begin
                    resetting <= 1'b0;
                end
            end
            if (sys_hit) begin
                case ({top7, 1'b0})
                    WAKE_OP: standby <= 1'b0;
                    STANDBY_OP: standby <= 1'b1;
                    RESET_OP: begin
                        filter_restart <= 1'b1;
                        regs_default <= 1'b1;
                        cont_mode <= CONT_MODE_RESET;
                        resetting <= 1'b1;
                        rst_cnt <= RESET_COUNT;
                    end
                    OFFSET_CALIBRATE_CMD: offset_cal <= 1'b1;
                    default: ;
                endcase
            end
            // on and cancel differ in bit 0, so both wait for the eighth
            if (state == ASD_IDLE && at8 &&
                byte_now == CONTINUOUS_OUTPUT_ON_CMD) begin
                cont_mode <= 1'b1;
            end
            if (state == ASD_IDLE && at8 &&
                byte_now == CONTINUOUS_OUTPUT_OFF_CMD) begin
                cont_mode <= 1'b0;
            end
        end
    end

    // conversions: start when running only clears a pending stop, stop lets current finish
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            converting <= RUN_RESET;
            pending_stop <= 1'b0;
        end else if (sys_hit && {top7, 1'b0} == RESET_OP) begin
            converting <= RUN_RESET;
            pending_stop <= 1'b0;
        end else if (sys_hit && {top7, 1'b0} == START_OP) begin
            converting <= 1'b1;
            pending_stop <= 1'b0;
        end else if (sys_hit && {top7, 1'b0} == STOP_OP) begin
            pending_stop <= converting;
        end else if (pending_stop && conv_done) begin
            converting <= 1'b0;
            pending_stop <= 1'b0;
        end
    end

    // result latch: each ready in continuous mode, or on-demand read
    logic ready_d;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_d <= 1'b1;
            result_load <= 1'b0;
        end else begin
            ready_d <= ready_s;
            result_load <= (cont_mode && ready_d && !ready_s) ||
                (sys_hit && {top7, 1'b0} == READ_ONCE_OP);
        end
    end
endmodule // asd_decoder

// ---- design/asd_pkg.sv ----
package asd_pkg;
    // single-byte opcodes
    localparam logic [7:0] WAKE_OP = 8'h02;
    localparam logic [7:0] STANDBY_OP = 8'h04;
    localparam logic [7:0] RESET_OP = 8'h06;
    localparam logic [7:0] START_OP = 8'h08;
    localparam logic [7:0] STOP_OP = 8'h0a;
    localparam logic [7:0] OFFSET_CALIBRATE_CMD = 8'h1a;
    localparam logic [7:0] CONTINUOUS_OUTPUT_ON_CMD = 8'h10;
    localparam logic [7:0] CONTINUOUS_OUTPUT_OFF_CMD = 8'h11;
    localparam logic [7:0] READ_ONCE_OP = 8'h12;
    // multi-byte opcode prefixes
    localparam logic [2:0] REGISTER_READ_CMD = 3'h1;
    localparam logic [2:0] REGISTER_WRITE_CMD = 3'h2;
    localparam logic [2:0] SECOND_BYTE_TOP = 3'h0;
    // bit counts
    localparam logic [3:0] SYS_DECODE_EDGE = 4'h7;
    localparam logic [3:0] REG_DECODE_EDGE = 4'h8;
    localparam logic [4:0] READ_DRIVE_EDGE = 5'h11;
    // timing, in master clock and modulator clock cycles
    localparam int RESET_MOD_CYCLES = 9;
    localparam int CLK_PER_MOD = 4;
    localparam int RESET_CYCLES = RESET_MOD_CYCLES * CLK_PER_MOD;
    localparam logic [5:0] RESET_COUNT = 6'(RESET_CYCLES);
    // reset values
    localparam logic CONT_MODE_RESET = 1'b1;
    localparam logic RUN_RESET = 1'b0;
    localparam logic STANDBY_RESET = 1'b0;

    typedef enum logic [4:0] {
        ASD_IDLE = 5'b00001,
        ASD_ARG = 5'b00010,
        ASD_RDATA = 5'b00100,
        ASD_WDATA = 5'b01000,
        ASD_SKIP = 5'b10000
    } asd_state_t;
endpackage

// ---- design/asd_sync.sv ----
module asd_sync #(
    // level held in reset, the pin's idle level
    parameter logic RESET_LEVEL = 1'b0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // raw and synchronised level
    input wire logic din,
    output logic dout
);
    logic stage1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RESET_LEVEL;
            dout <= RESET_LEVEL;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // asd_sync

// ---- design/asd_shift.sv ----
module asd_shift (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // synchronised link
    input wire logic cs_n_s,
    input wire logic sclk_s,
    input wire logic din_s,
    // edge and byte view
    output logic rise,
    output logic fall,
    output logic [7:0] shreg,
    output logic [4:0] bit_cnt
);
    logic sclk_d;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    assign rise = sclk_s & ~sclk_d & ~cs_n_s;
    assign fall = ~sclk_s & sclk_d & ~cs_n_s;

    // bits shift in on falling edges; count runs across the whole command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 8'h00;
            bit_cnt <= 5'h00;
        end else if (cs_n_s) begin
            bit_cnt <= 5'h00;
        end else if (fall) begin
            shreg <= {shreg[6:0], din_s};
            bit_cnt <= bit_cnt + 5'h01;
        end
    end
endmodule // asd_shift

// ---- dv/asd_sva.sv ----
module asd_sva
    import asd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // link and converter
    input wire logic cs_n,
    input wire logic conv_done,
    // strobes and levels
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic standby,
    input wire logic converting,
    input wire logic cont_mode,
    input wire logic filter_restart,
    input wire logic regs_default,
    input wire logic offset_cal,
    input wire logic resetting
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // --------
    // reset length counter
    // --------
    logic [6:0] rst_len;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rst_len <= 7'h00;
        else if (resetting)
            rst_len <= rst_len + 7'h01;
        else
            rst_len <= 7'h00;
    end

    property p_reset_len;
        $fell(resetting) |-> rst_len == 7'(RESET_CYCLES);
    endproperty
    a_reset_len: assert property (p_reset_len)
        else $error("reset execution length wrong");
    property p_reset_cap;
        resetting |-> rst_len < 7'(RESET_CYCLES);
    endproperty
    a_reset_cap: assert property (p_reset_cap)
        else $error("reset execution too long");
    property p_reset_quiet;
        resetting |-> !reg_wr && !reg_rd && !offset_cal;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("command acted on during reset");
    property p_cont_no_read;
        cont_mode |-> !reg_rd;
    endproperty
    a_cont_no_read: assert property (p_cont_no_read)
        else $error("register read in continuous mode");
    property p_power_up;
        !$past(rst_n) |-> cont_mode && !converting && !standby;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("wrong mode after reset");
    property p_one_strobe;
        !(reg_rd && reg_wr);
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("read and write strobe together");
    property p_cal_pulse;
        offset_cal |=> !offset_cal;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse)
        else $error("calibrate pulse too long");
    property p_restart_pair;
        filter_restart |-> regs_default ##1 resetting;
    endproperty
    a_restart_pair: assert property (p_restart_pair)
        else $error("filter restart without defaults");
    property p_stop_done;
        $fell(converting) && !standby && !resetting |-> $past(conv_done);
    endproperty
    a_stop_done: assert property (p_stop_done)
        else $error("conversions halted before completion");
    property p_idle_quiet;
        cs_n [*8] |-> !reg_wr && !reg_rd && !offset_cal;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("strobe while deselected");

    c_write: cover property (reg_wr);
    c_read: cover property (reg_rd);
    c_reset: cover property ($fell(resetting));
    c_stop: cover property ($fell(converting));
endmodule // asd_sva

bind asd_decoder asd_sva asd_sva_i (.sys_clk, .rst_n, .cs_n, .conv_done,
    .reg_rd, .reg_wr, .standby, .converting, .cont_mode, .filter_restart,
    .regs_default, .offset_cal, .resetting);

// ---- dv/asd_host.sv ----
module asd_host (
    // link to the device
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // select held over every byte; clock still outside frames
    task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] r;
        rx = {};
        r = 8'h00;
        cs_n = 1'b0;
        // odd offset keeps link edges clear of system clock edges
        #101;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                sclk = 1'b1;
                din = tx[k][i];
                #62.5;
                sclk = 1'b0;
                r = {r[6:0], dout};
                #62.5;
            end
            rx.push_back(r);
            #60;
        end
        cs_n = 1'b1;
        din = ~din;
    endtask
endmodule // asd_host

// ---- dv/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import asd_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic result_ready_n = 1'b1;
    logic conv_done = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic cs_n, sclk, din, dout, reg_rd, reg_wr, standby, converting;
    logic cont_mode, filter_restart, regs_default, offset_cal;
    logic result_load, resetting;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [31:0] seed = 32'h0000bc13;
    logic [12:0] wlog[$];
    logic [4:0] rlog[$];
    logic [7:0] rx[$];
    int pc[4] = '{0, 0, 0, 0};
    int num_errors = 0;
    int total_checks = 0;

    always #5 sys_clk = ~sys_clk;

    asd_decoder asd_decoder_i (.sys_clk, .rst_n, .cs_n, .sclk, .din, .dout,
        .result_ready_n, .conv_done, .rd_data, .reg_addr, .reg_rd, .reg_wr,
        .reg_wdata, .standby, .converting, .cont_mode, .filter_restart,
        .regs_default, .offset_cal, .result_load, .resetting);
    asd_host asd_host_i (.cs_n, .sclk, .din, .dout);

    // --------
    // monitors and helpers
    // --------
    always @(posedge sys_clk) begin
        if (reg_wr === 1'b1) wlog.push_back({reg_addr, reg_wdata});
        if (reg_rd === 1'b1) rlog.push_back(reg_addr);
        if (offset_cal === 1'b1) pc[0]++;
        if (filter_restart === 1'b1) pc[1]++;
        if (regs_default === 1'b1) pc[2]++;
        if (result_load === 1'b1) pc[3]++;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [31:0] st();
        return 32'({standby, converting, cont_mode, resetting});
    endfunction

    function automatic logic [31:0] exp_wr(logic [4:0] a, int i,
                                           logic [7:0] d);
        return 32'({a + 5'(i), d});
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] tx[$]);
        asd_host_i.frame(tx, rx);
        repeat (10) @(negedge sys_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #500000;
        num_errors++;
        tally_and_finish();
    end

    // --------
    // tests
    // --------
    initial begin
        logic [4:0] a;
        logic [4:0] n;
        logic [7:0] d[$];
        int p;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(st(), 32'h2);
        p = pc[3];
        result_ready_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        result_ready_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        check(32'(pc[3]), 32'(p + 1));
        p = rlog.size();
        cmd('{8'h20, 8'h00, 8'h00});
        check(32'(rlog.size()), 32'(p));
        cmd('{CONTINUOUS_OUTPUT_OFF_CMD});
        check(st(), 32'h0);
        $display("test modes done");
        cmd('{8'hff});
        cmd('{8'h03});
        cmd('{8'h45, 8'he0, 8'h5a});
        check(st(), 32'h0);
        check(32'(wlog.size()), 32'h0);
        $display("test unknown done");
        cmd('{START_OP});
        check(st(), 32'h4);
        cmd('{START_OP});
        check(st(), 32'h4);
        cmd('{STOP_OP});
        check(st(), 32'h4);
        conv_done = 1'b1;
        @(negedge sys_clk);
        conv_done = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(st(), 32'h0);
        cmd('{STOP_OP});
        check(st(), 32'h0);
        $display("test conversion done");
        p = pc[0];
        wlog = {};
        cmd('{8'h4a, 8'h00, 8'h80});
        check(32'(wlog[0]), exp_wr(5'h0a, 0, 8'h80));
        cmd('{OFFSET_CALIBRATE_CMD});
        check(32'(pc[0]), 32'(p + 1));
        cmd('{STANDBY_OP});
        check(st(), 32'h8);
        cmd('{WAKE_OP});
        check(st(), 32'h0);
        p = pc[3];
        cmd('{READ_ONCE_OP});
        check(32'(pc[3]), 32'(p + 1));
        cmd('{CONTINUOUS_OUTPUT_ON_CMD});
        check(st(), 32'h2);
        cmd('{CONTINUOUS_OUTPUT_OFF_CMD});
        p = pc[1] + pc[2];
        cmd('{RESET_OP});
        check(st(), 32'h3);
        check(32'(pc[1] + pc[2]), 32'(p + 2));
        repeat (40) @(negedge sys_clk);
        check(32'(resetting), 32'h0);
        cmd('{CONTINUOUS_OUTPUT_OFF_CMD});
        $display("test opcodes done");
        for (int t = 0; t < 4; t++) begin
            a = (t == 0) ? 5'h1d : 5'(rnd() % 8'h1d);
            n = (t == 0) ? 5'h02 : 5'(rnd() % 8'h03);
            d = '{8'h40 | 8'(a), 8'(n)};
            for (int i = 0; i <= n; i++) d.push_back(rnd());
            wlog = {};
            cmd(d);
            check(32'(wlog.size()), 32'(n) + 32'h1);
            for (int i = 0; i <= n; i++)
                check(32'(wlog[i]), exp_wr(a, i, d[i + 2]));
            rd_data = rnd();
            d = '{8'h20 | 8'(a), 8'(n)};
            for (int i = 0; i <= n; i++) d.push_back(8'h00);
            rlog = {};
            cmd(d);
            check(32'(rlog.size()), 32'(n) + 32'h1);
            for (int i = 0; i <= n; i++) begin
                check(32'(rlog[i]), 32'(a + 5'(i)));
                check(32'(rx[i + 2]), 32'(rd_data));
            end
        end
        $display("test registers done");
        tally_and_finish();
    end
endmodule // testbench
